/* include/ebb_pkg.sv */
// Constants, types and helpers for the EPP to backplane bridge
// Notes on behaviour
// - Handshake line idles low, rises to ack strobe fall, drops on rise.
// - All host port inputs are resynchronised to the backplane clock.
// - Address bits 7-4 pick the slot, bits 3-0 go to address bus.
// - Sixteen active-low slot enables; only the decoded slot is asserted.
// - A 4-bit register address bus is shared by all cards.
// - Backplane direction low for writes, high for reads, following host.
// - One active-low transfer strobe, one clock wide, per data cycle.
// - Backplane signals change and are sampled on the rising clock edge.
// - Slot enables and address change only on host address writes.
// - Old slot enable drops several clocks before the new one asserts.
// - Every address write drops slot enable; cards reset byte pointers.
// - Read mode: card drives the bus; write mode: only the bridge drives.
// - Drivers wait one clock after a direction change before enabling.
// - Each backplane transfer is one byte; wider values use byte runs.
// - A read from an empty slot returns all ones.
// - An address register latches address writes and reads them back.
// - Host init line low resets the bridge to idle.
package ebb_pkg;

  localparam int DATA_W     = 8;
  localparam int NSLOT      = 16;
  localparam int FIFO_DEPTH = 4;
  localparam int SLOT_MSB   = 7;
  localparam int SLOT_LSB   = 4;
  localparam int REG_MSB    = 3;
  localparam int REG_LSB    = 0;

  localparam logic [1:0]  SEL_GAP_CYC  = 2'h3;
  localparam logic [1:0]  READ_LAT_CYC = 2'h2;
  localparam logic [7:0]  IDLE_BUS     = 8'hFF;
  localparam logic [7:0]  ADDR_RST     = 8'h00;
  localparam logic [15:0] SEL_NONE     = 16'hFFFF;
  localparam logic        DIR_READ     = 1'b1;
  localparam logic        DIR_WRITE    = 1'b0;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_AGAP,
    ST_RTURN,
    ST_RWAIT,
    ST_ACK
  } ebb_state_e;

  // Active-low one-cold slot enable for a slot number
  function automatic logic [15:0] ebb_slot_dec(input logic [3:0] slot);
    logic [15:0] v;
    v = SEL_NONE;
    v[slot] = 1'b0;
    return v;
  endfunction

endpackage

/* include/ebb_fifo_if.sv */
// Valid/ready carrier between the bridge and its write byte FIFO
`timescale 1ns/1ns
interface ebb_fifo_if #(parameter int W = 8);
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] in_data;
  logic         out_valid;
  logic         out_ready;
  logic [W-1:0] out_data;

  modport fifo (input in_valid, in_data, out_ready,
                output in_ready, out_valid, out_data);
  modport user (output in_valid, in_data, out_ready,
                input in_ready, out_valid, out_data);
endinterface

/* rtl/ebb_fifo.sv */
// Small first-in first-out byte buffer with valid/ready on both sides
`timescale 1ns/1ns
module ebb_fifo
  import ebb_pkg::*;
#(
  parameter int W = 8,
  parameter int D = 4
) (
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic rst_i,
  // Buffer ports
  ebb_fifo_if.fifo  f
);
  localparam int PW = $clog2(D);
  localparam int CW = $clog2(D + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(D);

  logic [W-1:0]  mem [D];
  logic [PW-1:0] wr_ptr_reg, wr_ptr_next;
  logic [PW-1:0] rd_ptr_reg, rd_ptr_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic          do_push, do_pop;

  assign f.in_ready  = (cnt_reg != FULL_CNT);
  assign f.out_valid = (cnt_reg != '0);
  assign f.out_data  = mem[rd_ptr_reg];

  // Pointers wrap at the depth, which need not be a power of two
  always_comb begin
    do_push     = f.in_valid && f.in_ready;
    do_pop      = f.out_valid && f.out_ready;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    cnt_next    = cnt_reg;
    if (do_push) begin
      wr_ptr_next = (wr_ptr_reg == PW'(D - 1)) ? '0 : wr_ptr_reg + 1'b1;
    end
    if (do_pop) begin
      rd_ptr_next = (rd_ptr_reg == PW'(D - 1)) ? '0 : rd_ptr_reg + 1'b1;
    end
    if (do_push && !do_pop) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (do_pop && !do_push) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg    <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      cnt_reg    <= cnt_next;
    end
  end

  always_ff @(posedge clock_i) begin
    if (do_push) begin
      mem[wr_ptr_reg] <= f.in_data;
    end
  end

  a_fifo_count_bound: assert property (
    @(posedge clock_i) disable iff (rst_i) cnt_reg <= FULL_CNT)
    else $error("fifo count out of range");

  a_fifo_push_count: assert property (
    @(posedge clock_i) disable iff (rst_i)
    do_push && !do_pop |=> cnt_reg == $past(cnt_reg) + 1'b1)
    else $error("fifo push not counted");
endmodule

/* rtl/ebb_bridge.sv */
// EPP host port to synchronous card backplane bridge
`timescale 1ns/1ns
module ebb_bridge
  import ebb_pkg::*;
(
  // Clock and reset
  input  wire logic              clock_i,
  input  wire logic              rst_i,
  // Host parallel port
  input  wire logic              host_init_n_i,
  input  wire logic              host_as_n_i,
  input  wire logic              host_ds_n_i,
  input  wire logic              host_write_n_i,
  input  wire logic [DATA_W-1:0] host_data_i,
  output logic      [DATA_W-1:0] host_data_o,
  output logic                   host_data_oe_n_o,
  output logic                   host_wait_o,
  // Backplane
  output logic      [NSLOT-1:0]  per_slot_enable_n_o,
  output logic      [3:0]        bp_addr_o,
  output logic                   bp_read_o,
  output logic                   bp_strobe_n_o,
  input  wire logic [DATA_W-1:0] bp_data_i,
  output logic      [DATA_W-1:0] bp_data_o,
  output logic                   bp_data_oe_n_o
);

  // Synchronisers
  logic              init_s1, init_s2;
  logic              as_s1, as_s2;
  logic              ds_s1, ds_s2;
  logic              wr_s1, wr_s2;
  logic [DATA_W-1:0] hd_s1, hd_s2;
  logic              rst;

  // Control state
  ebb_state_e        state_reg, state_next;
  logic [1:0]        cnt_reg, cnt_next;
  logic              wait_reg, wait_next;
  logic [DATA_W-1:0] hd_reg, hd_next;
  logic              hd_oe_n_reg, hd_oe_n_next;
  logic [7:0]        addr_reg, addr_next;
  logic [NSLOT-1:0]  sel_reg, sel_next;
  logic              dir_reg, dir_next;
  logic              rstb_req;

  // Backplane drive state
  logic              stb_n_reg, stb_n_next;
  logic [DATA_W-1:0] bd_reg, bd_next;
  logic              bd_oe_n_reg, bd_oe_n_next;
  logic              pop;
  logic              push;
  logic              drain_idle;

  ebb_fifo_if #(.W(DATA_W)) f ();

  ebb_fifo #(
    .W (DATA_W),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .clock_i (clock_i),
    .rst_i   (rst),
    .f       (f)
  );

  // Pins are async to the backplane clock; data is sampled with strobes
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      init_s1 <= 1'b1;
      init_s2 <= 1'b1;
      as_s1   <= 1'b1;
      as_s2   <= 1'b1;
      ds_s1   <= 1'b1;
      ds_s2   <= 1'b1;
      wr_s1   <= 1'b1;
      wr_s2   <= 1'b1;
      hd_s1   <= '0;
      hd_s2   <= '0;
    end else begin
      init_s1 <= host_init_n_i;
      init_s2 <= init_s1;
      as_s1   <= host_as_n_i;
      as_s2   <= as_s1;
      ds_s1   <= host_ds_n_i;
      ds_s2   <= ds_s1;
      wr_s1   <= host_write_n_i;
      wr_s2   <= wr_s1;
      hd_s1   <= host_data_i;
      hd_s2   <= hd_s1;
    end
  end

  assign rst = rst_i || !init_s2;

  // No address write or backplane read until every queued write byte has been strobed out
  assign drain_idle = !f.out_valid && stb_n_reg;
  assign f.in_valid = push;
  assign f.in_data  = hd_s2;
  assign f.out_ready = pop;

  // Host handshake and addressing
  always_comb begin
    state_next   = state_reg;
    cnt_next     = cnt_reg;
    wait_next    = wait_reg;
    hd_next      = hd_reg;
    hd_oe_n_next = hd_oe_n_reg;
    addr_next    = addr_reg;
    sel_next     = sel_reg;
    dir_next     = dir_reg;
    rstb_req     = 1'b0;
    push         = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (!as_s2 && !wr_s2) begin
          if (drain_idle) begin
            sel_next  = SEL_NONE;
            addr_next = hd_s2;
            cnt_next  = SEL_GAP_CYC;
            state_next = ST_AGAP;
          end
        end else if (!as_s2 && wr_s2) begin
          hd_next      = addr_reg;
          hd_oe_n_next = 1'b0;
          wait_next    = 1'b1;
          state_next   = ST_ACK;
        end else if (!ds_s2 && !wr_s2) begin
          dir_next = DIR_WRITE;
          // FIFO full holds the handshake off until a byte drains
          if (f.in_ready) begin
            push       = 1'b1;
            wait_next  = 1'b1;
            state_next = ST_ACK;
          end
        end else if (!ds_s2 && wr_s2) begin
          if (drain_idle) begin
            dir_next   = DIR_READ;
            state_next = ST_RTURN;
          end
        end
      end
      ST_AGAP: begin
        cnt_next = cnt_reg - 1'b1;
        if (cnt_reg == 2'h1) begin
          sel_next   = ebb_slot_dec(addr_reg[SLOT_MSB:SLOT_LSB]);
          wait_next  = 1'b1;
          state_next = ST_ACK;
        end
      end
      ST_RTURN: begin
        // One clock for the card to turn its drivers on
        cnt_next   = READ_LAT_CYC;
        state_next = ST_RWAIT;
      end
      ST_RWAIT: begin
        cnt_next = cnt_reg - 1'b1;
        if (cnt_reg == 2'h1) begin
          hd_next      = sel_reg == SEL_NONE ? IDLE_BUS : bp_data_i;
          hd_oe_n_next = 1'b0;
          rstb_req     = 1'b1;
          wait_next    = 1'b1;
          state_next   = ST_ACK;
        end
      end
      ST_ACK: begin
        if (as_s2 && ds_s2) begin
          wait_next    = 1'b0;
          hd_oe_n_next = 1'b1;
          state_next   = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rst) begin
      state_reg   <= ST_IDLE;
      cnt_reg     <= '0;
      wait_reg    <= 1'b0;
      hd_reg      <= '0;
      hd_oe_n_reg <= 1'b1;
      addr_reg    <= ADDR_RST;
      sel_reg     <= SEL_NONE;
      dir_reg     <= DIR_READ;
    end else begin
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      wait_reg    <= wait_next;
      hd_reg      <= hd_next;
      hd_oe_n_reg <= hd_oe_n_next;
      addr_reg    <= addr_next;
      sel_reg     <= sel_next;
      dir_reg     <= dir_next;
    end
  end

  // Backplane write drain and strobes
  always_comb begin
    // Strobe stays high between bytes so each one is a separate pulse
    pop          = f.out_valid && !bd_oe_n_reg && stb_n_reg;
    stb_n_next   = !(pop || rstb_req);
    bd_next      = pop ? f.out_data : bd_reg;
    // Off on the edge read starts, on one clock after write starts
    bd_oe_n_next = dir_next || dir_reg;
  end

  always_ff @(posedge clock_i) begin
    if (rst) begin
      stb_n_reg   <= 1'b1;
      bd_reg      <= IDLE_BUS;
      bd_oe_n_reg <= 1'b1;
    end else begin
      stb_n_reg   <= stb_n_next;
      bd_reg      <= bd_next;
      bd_oe_n_reg <= bd_oe_n_next;
    end
  end

  assign host_data_o         = hd_reg;
  assign host_data_oe_n_o    = hd_oe_n_reg;
  assign host_wait_o         = wait_reg;
  assign per_slot_enable_n_o = sel_reg;
  assign bp_addr_o           = addr_reg[REG_MSB:REG_LSB];
  assign bp_read_o           = dir_reg;
  assign bp_strobe_n_o       = stb_n_reg;
  assign bp_data_o           = bd_reg;
  assign bp_data_oe_n_o      = bd_oe_n_reg;

  // Checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst);

  sequence s_rd_req;
    state_reg == ST_IDLE && !ds_s2 && !as_s2 == 1'b0 && wr_s2 && drain_idle;
  endsequence

  sequence s_rd_done;
    !stb_n_reg && wait_reg && !hd_oe_n_reg;
  endsequence

  sequence s_addr_rd;
    state_reg == ST_IDLE && !as_s2 && wr_s2;
  endsequence

  a_wait_rise_cause: assert property ($rose(wait_reg) |->
    $past(!as_s2 || !ds_s2))
    else $error("wait rose without a host strobe");

  a_wait_fall_cause: assert property ($fell(wait_reg) |->
    $past(as_s2 && ds_s2) && state_reg == ST_IDLE)
    else $error("wait fell while a strobe was low");

  a_strobe_one_wide: assert property ($fell(stb_n_reg) |=>
    stb_n_reg)
    else $error("transfer strobe longer than one clock");

  a_read_timing: assert property (s_rd_req |=> ##3 s_rd_done)
    else $error("read strobe not issued on time");

  a_sel_decode: assert property (sel_reg != SEL_NONE |->
    sel_reg == ebb_slot_dec(addr_reg[SLOT_MSB:SLOT_LSB]))
    else $error("slot enable does not match address");

  a_sel_gap: assert property (
    $changed(sel_reg) && sel_reg != SEL_NONE |->
    $past(sel_reg, 1) == SEL_NONE && $past(sel_reg, 3) == SEL_NONE)
    else $error("new slot enable too soon");

  a_addr_on_write: assert property ($changed(addr_reg) |->
    $past(state_reg) == ST_IDLE && $past(!as_s2 && !wr_s2)
    && sel_reg == SEL_NONE)
    else $error("address changed outside an address write");

  a_dir_follows: assert property ($fell(dir_reg) |->
    $past(!ds_s2 && !wr_s2))
    else $error("direction went to write without a write");

  a_drive_turn: assert property (!bd_oe_n_reg |->
    dir_reg == DIR_WRITE && $past(dir_reg) == DIR_WRITE)
    else $error("bridge drove the bus in read mode");

  a_empty_slot: assert property (
    state_reg == ST_RWAIT && cnt_reg == 2'h1
    && sel_reg == SEL_NONE |=> hd_reg == IDLE_BUS)
    else $error("empty slot read not all ones");

  a_addr_readback: assert property (s_addr_rd |=>
    hd_reg == $past(addr_reg) && !hd_oe_n_reg)
    else $error("address read did not return address");

  a_reset_quiet: assert property (disable iff (1'b0)
    $past(rst) |-> sel_reg == SEL_NONE && stb_n_reg && dir_reg == DIR_READ)
    else $error("backplane not quiet after reset");

  a_wait_hold: assert property (wait_reg && !(as_s2 && ds_s2) |=>
    wait_reg)
    else $error("wait dropped while a strobe was low");

  a_write_drive: assert property (
    !stb_n_reg && dir_reg == DIR_WRITE |-> !bd_oe_n_reg)
    else $error("write strobe without bridge driving data");

  a_read_turn: assert property (state_reg == ST_RWAIT |->
    dir_reg == DIR_READ && bd_oe_n_reg)
    else $error("bridge drove the bus during a read");
endmodule

/* testbench/ebb_host_model.sv */
// Host parallel port model running interlocked strobe cycles
`timescale 1ns/1ns
module ebb_host_model (
  // Clock
  input  wire logic       clock_i,
  // Handshake and data from the bridge
  input  wire logic       wait_i,
  input  wire logic [7:0] data_i,
  // Port lines driven by the host
  output logic            init_n_o,
  output logic            as_n_o,
  output logic            ds_n_o,
  output logic            write_n_o,
  output logic [7:0]      data_o,
  output logic            timeout_o
);
  initial begin
    init_n_o  = 1'b1;
    as_n_o    = 1'b1;
    ds_n_o    = 1'b1;
    write_n_o = 1'b1;
    data_o    = 8'h00;
    timeout_o = 1'b0;
  end

  // Bounded wait, sampled on the falling edge where the line is settled
  task automatic wait_for(input logic lvl);
    int n;
    n = 0;
    while (n < 300) begin
      @(negedge clock_i);
      if (wait_i === lvl) break;
      n++;
    end
    if (n >= 300) timeout_o = 1'b1;
  endtask

  // One strobe cycle; q is taken at the edge that shows the acknowledge
  task automatic cycle(input logic adr, input logic wr, input logic [7:0] d,
                       output logic [7:0] q);
    wait_for(1'b0);
    write_n_o = ~wr;
    data_o    = d;
    if (adr) as_n_o = 1'b0;
    else ds_n_o = 1'b0;
    wait_for(1'b1);
    q = data_i;
    as_n_o = 1'b1;
    ds_n_o = 1'b1;
    // Released bus shows a changed value, not a stale one
    data_o = ~d;
    wait_for(1'b0);
  endtask

  // Init line pulled low to restart the bridge
  task automatic init_pulse(input int n);
    init_n_o = 1'b0;
    repeat (n) @(negedge clock_i);
    init_n_o = 1'b1;
  endtask
endmodule

/* testbench/ebb_bridge_tb.sv */
// Self-checking bench for the host port to backplane bridge
`timescale 1ns/1ns
module ebb_bridge_tb;
  import ebb_pkg::*;
  localparam logic [3:0] CARD = 4'h3;
  // Arbitrary identity value for the bench card
  localparam logic [7:0] CARD_ID = 8'h5A;
  logic        clock_i, rst_i, init_n, as_n, ds_n, write_n, h_to, rd_ok;
  logic        host_oe_n, host_wait, bp_read, bp_strobe_n, bp_oe_n;
  logic        chg_ok, saw_none, s_prev, seen;
  logic [7:0]  h_drv, host_data_i, host_data_o, bp_data_i, bp_data_o, q, a;
  logic [7:0]  last, card_mem [16];
  logic [15:0] sel_n;
  logic [19:0] sa_prev;
  logic [3:0]  bp_addr;
  int          err_total, checked, seed, strobes, gap, nwr;

  ebb_bridge dut_u (.clock_i(clock_i), .rst_i(rst_i), .host_init_n_i(init_n),
    .host_as_n_i(as_n), .host_ds_n_i(ds_n), .host_write_n_i(write_n),
    .host_data_i(host_data_i), .host_data_o(host_data_o),
    .host_data_oe_n_o(host_oe_n), .host_wait_o(host_wait),
    .per_slot_enable_n_o(sel_n), .bp_addr_o(bp_addr), .bp_read_o(bp_read),
    .bp_strobe_n_o(bp_strobe_n), .bp_data_i(bp_data_i),
    .bp_data_o(bp_data_o), .bp_data_oe_n_o(bp_oe_n));
  ebb_host_model host_u (.clock_i(clock_i), .wait_i(host_wait),
    .data_i(host_data_i), .init_n_o(init_n), .as_n_o(as_n), .ds_n_o(ds_n),
    .write_n_o(write_n), .data_o(h_drv), .timeout_o(h_to));

  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end

  // Card in one slot; other slots empty, bus pulled up when undriven
  assign host_data_i = host_oe_n ? h_drv : host_data_o;
  assign bp_data_i = !bp_oe_n ? bp_data_o :
                     rd_ok ? card_mem[bp_addr] :
                     IDLE_BUS;
  // Register 0 of the card is its read-only identity
  always @(posedge clock_i) begin
    rd_ok <= !sel_n[CARD] && bp_read;
    if (!sel_n[CARD] && !bp_strobe_n && !bp_read && bp_addr != 4'h0) begin
      card_mem[bp_addr] <= bp_data_i;
    end
  end

  function automatic logic [7:0] exp_read(input logic [7:0] ad,
                                          input logic [7:0] wd);
    if (ad[7:4] != CARD) return IDLE_BUS;
    if (ad[3:0] == 4'h0) return CARD_ID;
    return wd;
  endfunction

  task automatic chk(input string nm, input logic [15:0] got,
                     input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic print_verdict();
    if (err_total == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge h_to) begin
    chk("handshake_wait", 16'h0000, 16'h0001);
    print_verdict();
  end

  // Wire monitors on settled values
  always @(negedge clock_i) begin
    if (!rst_i && init_n) begin
      if (!bp_strobe_n) begin
        strobes++;
        chk("strobe_width", {15'h0000, s_prev}, 16'h0001);
      end
      if (&sel_n) begin
        gap++;
        saw_none = 1'b1;
      end else begin
        if (gap != 0 && seen) begin
          chk("sel_gap", {15'h0000, gap >= 2}, 16'h0001);
        end
        gap = 0;
        seen = 1'b1;
      end
      if (!chg_ok) begin
        chk("sel_stable", sa_prev[15:0], sel_n);
        chk("addr_stable", 16'(sa_prev[19:16]), 16'(bp_addr));
      end
    end
    s_prev  = bp_strobe_n;
    sa_prev = {bp_addr, sel_n};
  end

  task automatic do_addr(input logic [7:0] ad);
    chg_ok   = 1'b1;
    saw_none = 1'b0;
    host_u.cycle(1'b1, 1'b1, ad, q);
    chk("sel_drop", {15'h0000, saw_none}, 16'h0001);
    chk("slot_en", sel_n, ~(16'h0001 << ad[7:4]));
    chk("reg_addr", {12'h000, bp_addr}, {12'h000, ad[3:0]});
    chk("wait_idle", {14'h0000, host_wait, host_oe_n}, 16'h0001);
    chg_ok = 1'b0;
    host_u.cycle(1'b1, 1'b0, 8'h00, q);
    chk("addr_back", {8'h00, q}, {8'h00, ad});
  endtask

  initial begin
    err_total = 0;
    checked   = 0;
    seed      = 87;
    strobes   = 0;
    gap       = 0;
    seen      = 1'b0;
    chg_ok    = 1'b1;
    s_prev    = 1'b1;
    sa_prev   = 20'h0_FFFF;
    last      = 8'h00;
    for (int i = 0; i < 16; i++) card_mem[i] = 8'h00;
    card_mem[0] = CARD_ID;
    rst_i = 1'b1;
    repeat (3) @(negedge clock_i);
    rst_i = 1'b0;
    chk("rst_sel", sel_n, SEL_NONE);
    chk("rst_ctl", {12'h000, bp_strobe_n, bp_read, host_wait, bp_oe_n},
        16'h000D);
    do_addr({CARD, 4'h0});
    host_u.cycle(1'b0, 1'b0, 8'h00, q);
    chk("card_id", {8'h00, q}, {8'h00, CARD_ID});
    a = 8'h00;
    for (int i = 0; i < 10; i++) begin
      // Corners: empty slot, same address twice, card slot with full burst
      if (i == 0) a = {4'hF, 4'h0};
      else if (i != 2) a = {(i % 3 == 1) ? CARD : 4'($random(seed)),
                            4'($random(seed))};
      do_addr(a);
      nwr = (i == 1) ? 6 : 1 + ($unsigned($random(seed)) % 6);
      strobes = 0;
      for (int k = 0; k < nwr; k++) begin
        last = 8'($random(seed));
        host_u.cycle(1'b0, 1'b1, last, q);
      end
      chk("bp_write_dir", {15'h0000, bp_read}, {15'h0000, DIR_WRITE});
      host_u.cycle(1'b1, 1'b0, 8'h00, q);
      chk("strobe_count", 16'(strobes), 16'(nwr));
      host_u.cycle(1'b0, 1'b0, 8'h00, q);
      chk("read_data", {8'h00, q},
          {8'h00, exp_read(a, last)});
      chk("bp_read_dir", {15'h0000, bp_read}, {15'h0000, DIR_READ});
    end
    do_addr({CARD, 4'h5});
    chg_ok = 1'b1;
    host_u.init_pulse(5);
    repeat (4) @(negedge clock_i);
    chk("init_sel", sel_n, SEL_NONE);
    chk("init_ctl", {14'h0000, bp_strobe_n, bp_read}, 16'h0003);
    host_u.cycle(1'b1, 1'b0, 8'h00, q);
    chk("init_addr", {8'h00, q}, {8'h00, ADDR_RST});
    host_u.cycle(1'b0, 1'b0, 8'h00, q);
    chk("noslot_read", {8'h00, q}, {8'h00, IDLE_BUS});
    print_verdict();
  end
endmodule
